// ===== sadc_consts.vh
// Register map, field positions, reset values and timing constants
`ifndef SADC_CONSTS_VH
`define SADC_CONSTS_VH
// Register indices; byte address is four times the index
`define SADC_IDX_RESULT 8'h1E
`define SADC_IDX_CTRL0 8'h1F
`define SADC_IDX_REFSEL 8'h9F
`define SADC_IDX_IRQ 8'hA0
`define SADC_IDX_PINCFG 8'hA1
`define SADC_IDX_PORTRD 8'hA2
// Control 0 fields
`define SADC_ON_BIT 0
`define SADC_INT_BIT 1
`define SADC_GO_BIT 2
`define SADC_CHLO_LSB 3
`define SADC_CS_LSB 6
// Control 1 field
`define SADC_REF_LSB 4
// Interrupt register fields
`define SADC_FLAG_BIT 6
`define SADC_IE_BIT 0
// Reset values
`define SADC_CTRL0_RST 8'h00
`define SADC_REFSEL_RST 2'h0
// Clock selections and dividers
`define SADC_CS_DIV2 2'h0
`define SADC_CS_DIV8 2'h1
`define SADC_CS_DIV32 2'h2
`define SADC_CS_RC 2'h3
`define SADC_DIV2 6'd2
`define SADC_DIV8 6'd8
`define SADC_DIV32 6'd32
// Timing in half converter-clock periods
`define SADC_CONV_HALF 5'd19
`define SADC_ABORT_HALF 5'd4
`define SADC_POST_HALF 5'd2
`endif

// ===== sadc_top.v
// Successive-approximation converter control with Wishbone registers
`timescale 1ns/1ps
`include "sadc_consts.vh"
// Overview of operation
// - module_on enables; clearing aborts any conversion
// - bits 7-6 select conversion clock source
// - channel_select from bits 5-3 and bit 1
// - external selection routes analog pin 0-7
// - internal: 000 reference, 001 dac output
// - start bit stays set, hardware clears when done
// - successive approximation gives eight-bit result
// - completion loads result and clears start bit
// - completion sets flag at bit six
// - enabled flag raises interrupt request
// - reference_config bits 5-4 select converter reference
// - control 1 unused bits read zero
// - sleep conversion only on dedicated rc clock
// - conversion ignores pin direction and select
// - analog-select disables pin digital input buffer
// - analog pins read zero in port data
// - result register readable and writable, no reset
// - clock codes: div2, div8, div32, rc
// - conversion takes nine and half periods
// - abort keeps result, acquire after two periods
// - one period hold disconnect after completion
module sadc_top (
    // Clock and reset
    input wire CORE_CLK,
    input wire ARST_N,
    // Wishbone slave
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [9:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    // Analog side
    input wire RC_CLK_TICK,
    input wire SLEEP_MODE,
    input wire COMP_IN,
    input wire [7:0] PIN_DIGITAL_IN,
    output reg [3:0] CHANNEL_SELECT,
    output reg INTERNAL_SOURCE_SELECT,
    output reg [1:0] CONVERTER_REFERENCE,
    output reg HOLD_CONNECT,
    output reg [7:0] DAC_TRIAL,
    output reg [7:0] INPUT_BUFFER_OFF,
    // Interrupt request
    output reg CONV_IRQ
);
    reg [7:0] ctrl0_reg;
    reg [1:0] refsel_reg;
    reg [7:0] result_reg;
    reg flag_reg;
    reg ie_reg;
    reg [7:0] analog_pin_select_reg;
    reg [1:0] state_reg;
    reg [4:0] half_reg;
    reg [5:0] div_reg;
    reg [7:0] sar_reg;
    reg [2:0] bit_reg;
    localparam ST_IDLE = 2'd0;
    localparam ST_CONV = 2'd1;
    localparam ST_ABORT = 2'd2;
    localparam ST_POST = 2'd3;
    wire [7:0] idx = WB_ADR_I[9:2];
    wire wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    wire wr_lo = wb_req & WB_WE_I & WB_SEL_I[0];
    wire [1:0] csel = ctrl0_reg[`SADC_CS_LSB+1:`SADC_CS_LSB];
    wire on = ctrl0_reg[`SADC_ON_BIT];
    // Half-period tick of the selected converter clock
    function [5:0] half_div;
        input [1:0] cs;
        begin
            case (cs)
                `SADC_CS_DIV2: half_div = `SADC_DIV2 >> 1;
                `SADC_CS_DIV8: half_div = `SADC_DIV8 >> 1;
                default: half_div = `SADC_DIV32 >> 1;
            endcase
        end
    endfunction
    wire div_hit = (div_reg == half_div(csel) - 6'd1);
    // RC tick is a half-period pulse from the oscillator; only it runs in sleep
    wire tick = (csel == `SADC_CS_RC) ? RC_CLK_TICK :
                (div_hit & ~SLEEP_MODE);
    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N)
            div_reg <= 6'd0;
        else if (div_hit | ~on)
            div_reg <= 6'd0;
        else
            div_reg <= div_reg + 6'd1;
    end
    // Software writes to control 0 and the start bit
    wire wr_ctrl0 = wr_lo & (idx == `SADC_IDX_CTRL0);
    wire sw_go = WB_DAT_I[`SADC_GO_BIT];
    wire sw_on = WB_DAT_I[`SADC_ON_BIT];
    wire busy = (state_reg == ST_CONV);
    wire sw_abort = wr_ctrl0 & busy & ~sw_go;
    wire start = wr_ctrl0 & sw_go & on & sw_on & (state_reg == ST_IDLE);
    // An abort or power-down write in the final tick wins over completion
    wire kill = wr_ctrl0 & ~(sw_go & sw_on);
    wire done = busy & tick & (half_reg == 5'd1) & ~kill;
    // Trial steps on every other half period; the first waits two ticks
    // so that the registered trial word has reached the comparator
    wire step = busy & tick & half_reg[0] & (half_reg > 5'd2) &
                (half_reg < `SADC_CONV_HALF);
    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl0_reg <= `SADC_CTRL0_RST;
            refsel_reg <= `SADC_REFSEL_RST;
            flag_reg <= 1'b0;
            ie_reg <= 1'b0;
            analog_pin_select_reg <= 8'h00;
            state_reg <= ST_IDLE;
            half_reg <= 5'd0;
            sar_reg <= 8'h00;
            bit_reg <= 3'd7;
        end else begin
            if (wr_ctrl0) begin
                ctrl0_reg <= WB_DAT_I[7:0];
                // Start only from idle with the module already on
                ctrl0_reg[`SADC_GO_BIT] <= start | (busy & sw_go & sw_on);
            end
            if (wr_lo & (idx == `SADC_IDX_REFSEL))
                refsel_reg <= WB_DAT_I[`SADC_REF_LSB+1:`SADC_REF_LSB];
            if (wr_lo & (idx == `SADC_IDX_IRQ))
                ie_reg <= WB_DAT_I[`SADC_IE_BIT];
            if (wr_lo & (idx == `SADC_IDX_PINCFG))
                analog_pin_select_reg <= WB_DAT_I[7:0];
            // Flag: set wins over a software clear
            if (done)
                flag_reg <= 1'b1;
            else if (wr_lo & (idx == `SADC_IDX_IRQ) & ~WB_DAT_I[`SADC_FLAG_BIT])
                flag_reg <= 1'b0;
            if (!on || (wr_ctrl0 && !sw_on)) begin
                state_reg <= ST_IDLE;
                ctrl0_reg[`SADC_GO_BIT] <= 1'b0;
            end else begin
                case (state_reg)
                    ST_IDLE: if (start) begin
                        state_reg <= ST_CONV;
                        half_reg <= `SADC_CONV_HALF;
                        sar_reg <= 8'h80;
                        bit_reg <= 3'd7;
                    end
                    ST_CONV: if (sw_abort) begin
                        state_reg <= ST_ABORT;
                        half_reg <= `SADC_ABORT_HALF;
                    end else if (done) begin
                        state_reg <= ST_POST;
                        half_reg <= `SADC_POST_HALF;
                        ctrl0_reg[`SADC_GO_BIT] <= 1'b0;
                    end else if (tick) begin
                        half_reg <= half_reg - 5'd1;
                        if (step) begin
                            // Keep or drop the trial bit, then try next
                            if (!COMP_IN)
                                sar_reg[bit_reg] <= 1'b0;
                            if (bit_reg != 3'd0) begin
                                sar_reg[bit_reg - 3'd1] <= 1'b1;
                                bit_reg <= bit_reg - 3'd1;
                            end
                        end
                    end
                    ST_ABORT, ST_POST: if (tick) begin
                        if (half_reg == 5'd1)
                            state_reg <= ST_IDLE;
                        half_reg <= half_reg - 5'd1;
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end
    // Result: no reset; completion wins over a same-cycle write
    always @(posedge CORE_CLK) begin
        if (done)
            result_reg <= sar_reg;
        else if (wr_lo & (idx == `SADC_IDX_RESULT))
            result_reg <= WB_DAT_I[7:0];
    end
    // Analog control outputs, driven from flip-flops
    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            CHANNEL_SELECT <= 4'h0;
            INTERNAL_SOURCE_SELECT <= 1'b0;
            CONVERTER_REFERENCE <= 2'h0;
            HOLD_CONNECT <= 1'b0;
            DAC_TRIAL <= 8'h00;
            INPUT_BUFFER_OFF <= 8'h00;
            CONV_IRQ <= 1'b0;
        end else begin
            // Pin config never gates conversion
            CHANNEL_SELECT <= {ctrl0_reg[`SADC_INT_BIT],
                ctrl0_reg[`SADC_CHLO_LSB+2:`SADC_CHLO_LSB]};
            INTERNAL_SOURCE_SELECT <= ctrl0_reg[`SADC_INT_BIT];
            CONVERTER_REFERENCE <= refsel_reg;
            // Acquire while on and idle; disconnected when off and in convert, abort and post
            HOLD_CONNECT <= on & (state_reg == ST_IDLE);
            DAC_TRIAL <= sar_reg;
            INPUT_BUFFER_OFF <= analog_pin_select_reg;
            CONV_IRQ <= flag_reg & ie_reg;
        end
    end
    // Wishbone: one-cycle ack, unmapped reads give zero
    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= wb_req;
            WB_DAT_O <= 32'h0000_0000;
            if (wb_req & ~WB_WE_I) begin
                case (idx)
                    `SADC_IDX_RESULT: WB_DAT_O[7:0] <= result_reg;
                    `SADC_IDX_CTRL0: WB_DAT_O[7:0] <= ctrl0_reg;
                    `SADC_IDX_REFSEL: WB_DAT_O[7:0] <=
                        {2'b00, refsel_reg, 4'h0};
                    `SADC_IDX_IRQ: WB_DAT_O[7:0] <=
                        {1'b0, flag_reg, 5'h00, ie_reg};
                    `SADC_IDX_PINCFG: WB_DAT_O[7:0] <= analog_pin_select_reg;
                    `SADC_IDX_PORTRD: WB_DAT_O[7:0] <=
                        PIN_DIGITAL_IN & ~analog_pin_select_reg;
                    default: WB_DAT_O <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // sadc_top

// ===== sadc_analog_model.sv
// Far side: sampled level, comparator and free-running RC clock
`timescale 1ns/1ps
module sadc_analog_model (
    // Clock and analog level
    input wire CORE_CLK,
    input wire [7:0] LEVEL,
    // Converter side
    input wire HOLD_CONNECT,
    input wire [7:0] DAC_TRIAL,
    output reg RC_CLK_TICK = 1'h0,
    output wire COMP_IN
);
    reg [7:0] held_reg = 8'h00;
    reg [1:0] div_reg = 2'h0;
    always @(posedge CORE_CLK) begin
        div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
        RC_CLK_TICK <= (div_reg == 2'h2);
        // Capacitor keeps its charge while disconnected
        if (HOLD_CONNECT)
            held_reg <= LEVEL;
    end
    assign COMP_IN = (held_reg >= DAC_TRIAL);
endmodule // sadc_analog_model

// ===== sadc_top_props.sv
// Port assertions for the converter control block
`timescale 1ns/1ps
`include "sadc_consts.vh"
module sadc_top_props (
    // Clock and reset
    input wire CORE_CLK,
    input wire ARST_N,
    // Bus
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [9:0] WB_ADR_I,
    input wire [31:0] WB_DAT_O,
    input wire WB_ACK_O,
    // Converter side
    input wire [7:0] PIN_DIGITAL_IN,
    input wire [3:0] CHANNEL_SELECT,
    input wire INTERNAL_SOURCE_SELECT,
    input wire [1:0] CONVERTER_REFERENCE,
    input wire [7:0] INPUT_BUFFER_OFF,
    input wire CONV_IRQ
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);
    wire tk = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    wire [7:0] ix = WB_ADR_I[9:2];
    wire rd = tk & ~WB_WE_I;
    wire wc = tk & WB_WE_I & (ix == `SADC_IDX_CTRL0);
    wire wf = tk & WB_WE_I & (ix == `SADC_IDX_REFSEL);
    wire wq = tk & WB_WE_I & (ix == `SADC_IDX_IRQ);
    wire wp = tk & WB_WE_I & (ix == `SADC_IDX_PINCFG);
    property p_ack; tk |=> WB_ACK_O ##1 !WB_ACK_O; endproperty
    a_ack: assert property (p_ack) else $error("ack not one pulse");
    property p_ref_rd; rd && ix == `SADC_IDX_REFSEL |=>
        WB_DAT_O[31:6] == 26'h0 && WB_DAT_O[3:0] == 4'h0; endproperty
    a_ref_rd: assert property (p_ref_rd)
        else $error("unused reference bits not zero");
    property p_port; rd && ix == `SADC_IDX_PORTRD |=> WB_DAT_O ==
        {24'h0, $past(PIN_DIGITAL_IN) & ~$past(INPUT_BUFFER_OFF)}; endproperty
    a_port: assert property (p_port)
        else $error("analog pin not read as zero");
    property p_flag; $fell(CONV_IRQ) |-> wq || $past(wq) || $past(wq, 2);
    endproperty
    a_flag: assert property (p_flag)
        else $error("flag dropped without software");
    property p_ref; $changed(CONVERTER_REFERENCE) |-> $past(wf, 2);
    endproperty
    a_ref: assert property (p_ref)
        else $error("reference changed without write");
    property p_chan; $changed(CHANNEL_SELECT) |-> $past(wc, 2); endproperty
    a_chan: assert property (p_chan)
        else $error("channel changed without write");
    property p_int; INTERNAL_SOURCE_SELECT == CHANNEL_SELECT[3]; endproperty
    a_int: assert property (p_int)
        else $error("internal select disagrees");
    property p_buf; $changed(INPUT_BUFFER_OFF) |-> $past(wp, 2); endproperty
    a_buf: assert property (p_buf)
        else $error("buffer control changed without write");
endmodule // sadc_top_props
bind sadc_top sadc_top_props sadc_top_props_inst (.CORE_CLK, .ARST_N,
    .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_DAT_O, .WB_ACK_O,
    .PIN_DIGITAL_IN, .CHANNEL_SELECT, .INTERNAL_SOURCE_SELECT,
    .CONVERTER_REFERENCE, .INPUT_BUFFER_OFF, .CONV_IRQ);

// ===== sadc_top_tb.sv
// Register-level bench for the converter control block
`timescale 1ns/1ps
`include "sadc_consts.vh"
`define CHK(a, b) begin checks = checks + 1; if ((a) !== (b)) begin \
    n_fail = n_fail + 1; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module sadc_top_tb;
    reg clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, sleep = 0;
    reg [9:0] adr = 10'h000;
    reg [31:0] dat = 32'h0;
    reg [7:0] pins = 8'hFF, level = 8'h00, q, cv;
    wire [31:0] dat_o;
    wire ack, tick, comp, iss, hold, irq;
    wire [3:0] chs;
    wire [1:0] cref;
    wire [7:0] trial, buf_off;
    integer n_fail = 0, checks = 0, i, n, k;
    sadc_top sadc_top_inst (.CORE_CLK(clk), .ARST_N(rst_n), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1),
        .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .RC_CLK_TICK(tick), .SLEEP_MODE(sleep), .COMP_IN(comp),
        .PIN_DIGITAL_IN(pins), .CHANNEL_SELECT(chs),
        .INTERNAL_SOURCE_SELECT(iss), .CONVERTER_REFERENCE(cref),
        .HOLD_CONNECT(hold), .DAC_TRIAL(trial), .INPUT_BUFFER_OFF(buf_off),
        .CONV_IRQ(irq));
    sadc_analog_model sadc_analog_model_inst (.CORE_CLK(clk), .LEVEL(level),
        .HOLD_CONNECT(hold), .DAC_TRIAL(trial), .RC_CLK_TICK(tick),
        .COMP_IN(comp));
    initial forever #4 clk = ~clk;
    task acc(input [7:0] ix, input w, input [7:0] d);
        begin
            n = 0;
            cyc <= 1'h1;
            stb <= 1'h1;
            we <= w;
            adr <= {ix, 2'h0};
            dat <= {24'h0, d};
            @(posedge clk);
            while (ack !== 1'h1 && n < 50) begin
                @(posedge clk);
                n = n + 1;
            end
            if (n == 50) n_fail = n_fail + 1;
            q = dat_o[7:0];
            cyc <= 1'h0;
            stb <= 1'h0;
            @(posedge clk);
        end
    endtask
    task rd_chk(input [7:0] ix, input [7:0] e);
        begin
            acc(ix, 1'h0, 8'h00);
            `CHK(q, e)
        end
    endtask
    // Poll until the start bit drops; a stuck bit is caught by the caller
    task poll;
        begin
            k = 0;
            q = 8'h04;
            while (q[2] === 1'h1 && k < 300) begin
                acc(`SADC_IDX_CTRL0, 1'h0, 8'h00);
                k = k + 1;
            end
        end
    endtask
    task final_report;
        begin
            $display("checks=%0d n_fail=%0d", checks, n_fail);
            if (n_fail == 0 && checks > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    initial begin
        #400000;
        n_fail = n_fail + 1;
        final_report;
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        rd_chk(`SADC_IDX_CTRL0, `SADC_CTRL0_RST);
        for (i = 0; i < 4; i = i + 1) begin
            acc(`SADC_IDX_REFSEL, 1'h1, 8'hCF | {2'h0, i[1:0], 4'h0});
            rd_chk(`SADC_IDX_REFSEL, {2'h0, i[1:0], 4'h0});
            `CHK(cref, i[1:0])
        end
        acc(`SADC_IDX_RESULT, 1'h1, 8'hA5);
        rd_chk(`SADC_IDX_RESULT, 8'hA5);
        acc(`SADC_IDX_CTRL0, 1'h1, 8'h04);
        rd_chk(`SADC_IDX_CTRL0, 8'h00);
        $display("test registers done");
        acc(`SADC_IDX_IRQ, 1'h1, 8'h01);
        for (i = 0; i < 4; i = i + 1) begin
            cv = {i[1:0], (i == 1) ? 3'h1 : (i == 3) ? 3'h0 : 3'h5,
                1'h0, i[0], 1'h1};
            level <= {i[1:0], 6'h2B};
            sleep <= (i == 3);
            acc(`SADC_IDX_CTRL0, 1'h1, cv);
            `CHK({iss, chs}, {i[0], i[0], cv[5:3]})
            // Let the post-conversion hold of the last run end first
            repeat (40) @(posedge clk);
            acc(`SADC_IDX_CTRL0, 1'h1, cv | 8'h04);
            rd_chk(`SADC_IDX_CTRL0, cv | 8'h04);
            `CHK(hold, 1'h0)
            poll;
            `CHK(q, cv)
            rd_chk(`SADC_IDX_RESULT, {i[1:0], 6'h2B});
            `CHK(trial, {i[1:0], 6'h2B})
            rd_chk(`SADC_IDX_IRQ, 8'h41);
            `CHK(irq, 1'h1)
            acc(`SADC_IDX_IRQ, 1'h1, 8'h01);
            `CHK(irq, 1'h0)
        end
        $display("test conversions done");
        acc(`SADC_IDX_CTRL0, 1'h1, 8'h45);
        repeat (100) @(posedge clk);
        rd_chk(`SADC_IDX_CTRL0, 8'h45);
        sleep <= 1'h0;
        poll;
        `CHK(q, 8'h41)
        level <= 8'h99;
        acc(`SADC_IDX_CTRL0, 1'h1, 8'h81);
        repeat (40) @(posedge clk);
        acc(`SADC_IDX_CTRL0, 1'h1, 8'h85);
        acc(`SADC_IDX_CTRL0, 1'h1, 8'h81);
        `CHK(hold, 1'h0)
        rd_chk(`SADC_IDX_RESULT, 8'hEB);
        repeat (80) @(posedge clk);
        `CHK(hold, 1'h1)
        acc(`SADC_IDX_CTRL0, 1'h1, 8'h85);
        acc(`SADC_IDX_CTRL0, 1'h1, 8'h80);
        rd_chk(`SADC_IDX_CTRL0, 8'h80);
        rd_chk(`SADC_IDX_RESULT, 8'hEB);
        $display("test aborts done");
        acc(`SADC_IDX_PINCFG, 1'h1, 8'h0F);
        rd_chk(`SADC_IDX_PORTRD, 8'hF0);
        `CHK(buf_off, 8'h0F)
        $display("test pins done");
        final_report;
    end
endmodule // sadc_top_tb
